//--- core/hci_host_cmd.sv
// host command interpreter: decodes host accesses and drives cpu control
// Summary of operation
// RULE_01 - bits 17:16 00 memory word by bits 15:0; 01 diagnostic port
// RULE_02 - on access: stop cpu clocks, drop cpu buffers, enable transceivers; code enables transceivers only for groups 00 and 01
// RULE_03 - host write-enable level chooses read or write of selected word
// RULE_04 - group 10: illegal, halt, run, steps all/ctrl/data, irq, reset
// RULE_05 - group 11 codes: illegal, loads, capture, shift store, shift opcode
// RULE_06 - halt stops clocks until run; single steps override it briefly
// RULE_07 - run lets the system clocks run freely
// RULE_08 - single step cycles all clocks once; gated clocks keep own enables
// RULE_09 - control step pulses only control-section clocks once
// RULE_10 - data step pulses only data-section clocks once
// RULE_11 - interrupt command sets a request input of the interrupt controller
// RULE_12 - reset command asserts system reset and steps ungated clocks
// RULE_13 - load pipeline clocks pipeline and store port once, forced load
// RULE_14 - load opcode clocks opcode, operand, status, base regs from chain
// RULE_15 - load store runs a cycle sequence writing chain data into store
// RULE_16 - load init loads only the store initialize registers
// RULE_17 - capture copies every pipeline register into its chain element
// RULE_18 - shift store chain exchanges port bits with store chain
// RULE_19 - shift opcode chain exchanges port bits with opcode chain
// RULE_20 - host never issues an illegal code; controller then hangs
// RULE_21 - ready low until done, high until deselect, then restore and idle
// RULE_22 - host holds select until ready; host inputs are synchronised
// RULE_23 - shift commands carry a nibble count for partial shifts
`timescale 1ns/100ps
`default_nettype none
module hci_host_cmd
   import hci_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   // host side, asynchronous
   input wire logic hostSelect,
   input wire logic hostWriteEn,
   input wire logic [hci_pkg::ADDR_W-1:0] hostAddr,
   input wire logic [hci_pkg::NIB_W-1:0] hostNibbles,
   input wire logic [hci_pkg::PORT_W-1:0] hostDataIn,
   output logic [hci_pkg::PORT_W-1:0] hostDataOut,
   output logic host_wait_release,
   // internal bus ownership
   output logic xcvrEnable,
   output logic cpuBufEnable,
   output logic memEnable,
   output logic memWriteEn,
   output logic [hci_pkg::WORD_HI:0] mem_addr_bus,
   output logic [hci_pkg::PORT_W-1:0] memWriteData,
   input wire logic [hci_pkg::PORT_W-1:0] mem_data_bus,
   // clock control to the processor
   output logic sysClockRun,
   output logic ctrlClockPulse,
   output logic dataClockPulse,
   output logic ungatedOnly,
   output logic forceGated,
   output logic sysReset,
   output logic irqRequest,
   // shadow chain control
   output logic shadowForceLoad,
   output logic pipeLoadClk,
   output logic opcLoadClk,
   output logic storeWrite,
   output logic storeInitLoad,
   output logic shadowCapture,
   output logic storeChainClk,
   output logic opcChainClk,
   output logic chainBitOut,
   input wire logic storeChainBitIn,
   input wire logic opcChainBitIn
);
   localparam int SYNC_W = ADDR_W + NIB_W + PORT_W + 2;

   hci_state_t state, next_state;
   logic [SYNC_W-1:0] syncBus;
   logic selS, weS;
   logic [ADDR_W-1:0] addrS;
   logic [NIB_W-1:0] nibS;
   logic [PORT_W-1:0] dinS;
   logic halted;
   logic [SHIFT_CNT_W-1:0] count;
   logic [PORT_W-1:0] portReg;
   logic [ADDR_W-1:0] cmdAddr;
   logic cmdWe;

   // every host input crosses two flip-flops before use
   hci_sync #(.W(SYNC_W)) u_sync (  // see RULE_22
      .clock(clock),
      .rst_b(rst_b),
      .async_in({hostSelect, hostWriteEn, hostAddr, hostNibbles, hostDataIn}),
      .sync_out(syncBus)
   );
   assign {selS, weS, addrS, nibS, dinS} = syncBus;

   // command decode on the latched address
   wire [1:0] grp = cmdAddr[GRP_HI:GRP_LO];  // see RULE_01
   wire [2:0] code = cmdAddr[CODE_HI:0];
   wire isMem = grp == GRP_MEM;
   wire isPort = grp == GRP_PORT;
   wire isCpu = grp == GRP_CPU;  // see RULE_04
   wire isDiag = grp == GRP_DIAG;  // see RULE_05
   wire isIllegal = (isCpu || isDiag) && code == 3'h0;
   wire isShift = isDiag && (code == DG_SHSTORE || code == DG_SHOPC);
   wire isStore = isDiag && code == DG_LDSTORE;
   wire execOn = state == ST_EXEC;
   wire firstExec = execOn && count == '0;
   // nibble count zero stands for a full 32-bit port shift
   wire [SHIFT_CNT_W-1:0] shiftLen = (nibS == '0) ? SHIFT_CNT_W'(PORT_W)
      : SHIFT_CNT_W'({nibS, 2'b00});  // see RULE_23
   wire [SHIFT_CNT_W-1:0] lastCount = isShift ? shiftLen - 1'b1
      : isStore ? SHIFT_CNT_W'(STORE_CYCLES - 1'b1)
      : (isMem || isPort) ? SHIFT_CNT_W'(MEM_CYCLES - 1'b1)
      : '0;
   wire execLast = execOn && count == lastCount;
   wire chainIn = (code == DG_SHSTORE) ? storeChainBitIn : opcChainBitIn;

   // sequencer: idle, decode, execute, hold ready, illegal trap
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (selS) next_state = ST_DECODE;
         ST_DECODE: next_state = isIllegal ? ST_TRAP : ST_EXEC;
         ST_EXEC: if (execLast) next_state = ST_DONE;
         ST_DONE: if (!selS) next_state = ST_IDLE;  // see RULE_21
         ST_TRAP: next_state = ST_TRAP;  // deliberate hang, see RULE_20
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // latch command at selection so host bits may settle meanwhile
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cmdAddr <= '0;
         cmdWe <= 1'b0;
      end else if (state == ST_IDLE && selS) begin
         cmdAddr <= addrS;
         cmdWe <= weS;  // see RULE_03
      end
   end

   // cycle counter within execute
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         count <= '0;
      end else if (execOn && !execLast) begin
         count <= count + 1'b1;
      end else begin
         count <= '0;
      end
   end

   // halt mode flag, persistent across transactions
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         halted <= 1'b0;
      end else if (firstExec && isCpu && code == CPU_HALT) begin
         halted <= 1'b1;  // see RULE_06
      end else if (firstExec && isCpu && code == CPU_RUN) begin
         halted <= 1'b0;  // see RULE_07
      end
   end

   // port register: host load, read-back, chain exchange
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         portReg <= PORT_RESET;
      end else if (firstExec && isPort && cmdWe) begin
         portReg <= dinS;
      end else if (execOn && isShift) begin
         portReg <= {chainIn, portReg[PORT_W-1:1]};  // see RULE_18, RULE_19
      end
   end

   // data returned to host comes from a register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hostDataOut <= '0;
         memWriteData <= '0;
      end else if (firstExec && isMem) begin
         hostDataOut <= mem_data_bus;
         memWriteData <= dinS;
      end else if (execLast && isPort) begin
         hostDataOut <= portReg;
      end
   end

   // bus ownership follows the transaction; transceivers enable only for memory or port commands
   wire owned = state != ST_IDLE && state != ST_DECODE;
   assign xcvrEnable = owned && (isMem || isPort);  // see RULE_02
   assign cpuBufEnable = !owned;  // see RULE_02
   assign memEnable = execOn && isMem;
   assign memWriteEn = execOn && isMem && cmdWe && count == lastCount;
   assign mem_addr_bus = cmdAddr[WORD_HI:0];  // see RULE_01
   assign host_wait_release = state == ST_DONE;  // see RULE_21

   // free-run clock: stopped while halted or while the host owns the bus
   assign sysClockRun = !halted && !owned;  // see RULE_02, RULE_06, RULE_21
   wire stepAll = firstExec && isCpu && code == CPU_STEP;  // see RULE_08
   wire stepRst = firstExec && isCpu && code == CPU_RESET;
   assign ctrlClockPulse = stepAll || stepRst
      || (firstExec && isCpu && code == CPU_STEPC);  // see RULE_09
   assign dataClockPulse = stepAll || stepRst
      || (firstExec && isCpu && code == CPU_STEPD);  // see RULE_10
   // gated clocks follow their own enables; only reset restricts to ungated
   assign forceGated = 1'b0;  // see RULE_08
   assign ungatedOnly = stepRst;  // see RULE_12
   assign sysReset = execOn && isCpu && code == CPU_RESET;  // see RULE_12
   assign irqRequest = firstExec && isCpu && code == CPU_IRQ;  // see RULE_11

   // diagnostic chain strobes
   wire dg = execOn && isDiag;
   assign pipeLoadClk = dg && code == DG_LDPIPE;  // see RULE_13
   assign opcLoadClk = dg && code == DG_LDOPC;  // see RULE_14
   assign shadowForceLoad = pipeLoadClk || opcLoadClk;
   assign storeWrite = dg && code == DG_LDSTORE;  // see RULE_15
   assign storeInitLoad = dg && code == DG_LDINIT;  // see RULE_16
   assign shadowCapture = dg && code == DG_CAPTURE;  // see RULE_17
   assign storeChainClk = dg && code == DG_SHSTORE;  // see RULE_18
   assign opcChainClk = dg && code == DG_SHOPC;  // see RULE_19
   assign chainBitOut = portReg[0];

   // ready only after execution completes, and drops once deselected
   chk_ready_after_exec: assert property (  // see RULE_21
      @(posedge clock) disable iff (!rst_b)
      $rose(host_wait_release) |-> $past(execLast))
      else $error("ready rose without completion");
   chk_ready_drop: assert property (  // see RULE_21
      @(posedge clock) disable iff (!rst_b)
      host_wait_release && !selS |=> !host_wait_release ##1 cpuBufEnable)
      else $error("ready not released after deselect");
   // ready must stay low while the command is still being worked on
   chk_wait_held: assert property (  // see RULE_21
      @(posedge clock) disable iff (!rst_b)
      execOn || state == ST_DECODE |-> !host_wait_release)
      else $error("ready high before completion");
   chk_bus_swap: assert property (  // see RULE_02
      @(posedge clock) disable iff (!rst_b)
      xcvrEnable |-> !cpuBufEnable && !sysClockRun)
      else $error("transceivers and cpu buffers overlap");
   // a memory or port access owns the bus for its whole execution
   chk_bus_taken: assert property (  // see RULE_02
      @(posedge clock) disable iff (!rst_b)
      execOn && (isMem || isPort) |-> xcvrEnable && !cpuBufEnable)
      else $error("host access without bus ownership");
   chk_halt_hold: assert property (  // see RULE_06
      @(posedge clock) disable iff (!rst_b)
      halted && !(firstExec && isCpu && code == CPU_RUN) |=> halted)
      else $error("halt lost without run");
   chk_halt_stops: assert property (  // see RULE_06
      @(posedge clock) disable iff (!rst_b)
      halted |-> !sysClockRun)
      else $error("free clock running while halted");
   chk_run_frees: assert property (  // see RULE_07
      @(posedge clock) disable iff (!rst_b)
      firstExec && isCpu && code == CPU_RUN |=> !halted)
      else $error("run did not clear halt");
   chk_ctrl_only: assert property (  // see RULE_09
      @(posedge clock) disable iff (!rst_b)
      firstExec && isCpu && code == CPU_STEPC |-> ctrlClockPulse
      && !dataClockPulse)
      else $error("control step touched data section");
   chk_data_only: assert property (  // see RULE_10
      @(posedge clock) disable iff (!rst_b)
      firstExec && isCpu && code == CPU_STEPD |-> dataClockPulse
      && !ctrlClockPulse)
      else $error("data step touched control section");
   chk_step_once: assert property (  // see RULE_08
      @(posedge clock) disable iff (!rst_b)
      ctrlClockPulse |=> !ctrlClockPulse)
      else $error("step pulse longer than one cycle");
   chk_step_all: assert property (  // see RULE_08
      @(posedge clock) disable iff (!rst_b)
      stepAll |-> ctrlClockPulse && dataClockPulse && !forceGated
      && !ungatedOnly)
      else $error("single step did not pulse both sections");
   // reset command: reset line together with one ungated step
   chk_reset_step: assert property (  // see RULE_12
      @(posedge clock) disable iff (!rst_b)
      sysReset |-> ungatedOnly && ctrlClockPulse && dataClockPulse)
      else $error("reset without ungated clock step");
   chk_irq_pulse: assert property (  // see RULE_11
      @(posedge clock) disable iff (!rst_b)
      irqRequest |=> !irqRequest)
      else $error("interrupt request longer than one cycle");
   // forced loads are single-cycle strobes, else the chain gets loaded twice
   chk_load_once: assert property (  // see RULE_13, RULE_14
      @(posedge clock) disable iff (!rst_b)
      pipeLoadClk || opcLoadClk |-> shadowForceLoad
      ##1 !(pipeLoadClk || opcLoadClk))
      else $error("forced load not a single cycle");
   // store write sequence lasts exactly the four store cycles
   chk_store_seq: assert property (  // see RULE_15
      @(posedge clock) disable iff (!rst_b)
      $rose(storeWrite) |-> storeWrite[*4] ##1 !storeWrite)
      else $error("store write sequence length wrong");
   // a one-nibble shift clocks its chain exactly four times, then stops
   chk_shift_len: assert property (  // see RULE_23
      @(posedge clock) disable iff (!rst_b)
      $rose(execOn) && isShift && nibS == 4'h1
      |-> (storeChainClk || opcChainClk)[*4]
      ##1 !(storeChainClk || opcChainClk))
      else $error("shift length wrong");
endmodule
`default_nettype wire

//--- core/hci_pkg.sv
// constants and types shared by the host command interpreter
package hci_pkg;
   // decoded function groups on address bits 17:16
   localparam logic [1:0] GRP_MEM = 2'h0;
   localparam logic [1:0] GRP_PORT = 2'h1;
   localparam logic [1:0] GRP_CPU = 2'h2;
   localparam logic [1:0] GRP_DIAG = 2'h3;
   // field positions in the host address
   localparam int ADDR_W = 18;
   localparam int GRP_HI = 17;
   localparam int GRP_LO = 16;
   localparam int WORD_HI = 15;
   localparam int CODE_HI = 2;
   // cpu group codes
   localparam logic [2:0] CPU_HALT = 3'h1;
   localparam logic [2:0] CPU_RUN = 3'h2;
   localparam logic [2:0] CPU_STEP = 3'h3;
   localparam logic [2:0] CPU_STEPC = 3'h4;
   localparam logic [2:0] CPU_STEPD = 3'h5;
   localparam logic [2:0] CPU_IRQ = 3'h6;
   localparam logic [2:0] CPU_RESET = 3'h7;
   // diagnostic group codes
   localparam logic [2:0] DG_LDPIPE = 3'h1;
   localparam logic [2:0] DG_LDOPC = 3'h2;
   localparam logic [2:0] DG_LDSTORE = 3'h3;
   localparam logic [2:0] DG_LDINIT = 3'h4;
   localparam logic [2:0] DG_CAPTURE = 3'h5;
   localparam logic [2:0] DG_SHSTORE = 3'h6;
   localparam logic [2:0] DG_SHOPC = 3'h7;
   // timing in cycles
   localparam logic [3:0] MEM_CYCLES = 4'h2;   // host memory/port access
   localparam logic [3:0] STORE_CYCLES = 4'h4; // store write sequence
   localparam int NIB_W = 4;                   // nibble count field width
   localparam int PORT_W = 32;
   localparam int SHIFT_CNT_W = 6;
   localparam logic [PORT_W-1:0] PORT_RESET = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b011,
      ST_TRAP = 3'b100
   } hci_state_t;
endpackage

//--- core/hci_sync.sv
// two flip-flop synchroniser for a bundle of host inputs
`timescale 1ns/100ps
`default_nettype none
module hci_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

//--- test/hci_far_model.sv
// far-side model: system memory and the two shadow chains
`timescale 1ns/100ps
`default_nettype none
module hci_far_model #(
   parameter logic [63:0] SC_INIT = 64'h0000_0000_0000_0000,
   parameter logic [63:0] OC_INIT = 64'h0000_0000_0000_0000
) (
   input wire logic clock,
   input wire logic memEnable,
   input wire logic memWriteEn,
   input wire logic [15:0] memAddr,
   input wire logic [31:0] memWriteData,
   output logic [31:0] memData,
   input wire logic storeChainClk,
   input wire logic opcChainClk,
   input wire logic chainBitOut,
   output logic storeChainBit,
   output logic opcChainBit
);
   logic [31:0] mem [0:255];
   logic [31:0] lastData = 32'h0000_0000;
   logic [63:0] sc = SC_INIT;
   logic [63:0] oc = OC_INIT;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 32'h5a00_0000 | i;
   end
   // a released bus shows the inverse of its last value, never a stale copy
   assign memData = memEnable ? mem[memAddr[7:0]] : ~lastData;
   assign storeChainBit = sc[0];
   assign opcChainBit = oc[0];
   // writes and chain shifts act on the rising edge
   always @(posedge clock) begin
      lastData <= memData;
      if (memEnable && memWriteEn) mem[memAddr[7:0]] <= memWriteData;
      if (storeChainClk) sc <= {chainBitOut, sc[63:1]};
      if (opcChainClk) oc <= {chainBitOut, oc[63:1]};
   end
endmodule
`default_nettype wire

//--- test/hci_host_cmd_tb.sv
// self-checking bench for the host command interpreter
`timescale 1ns/100ps
`default_nettype none
module hci_host_cmd_tb;
   import hci_pkg::*;
   localparam logic [63:0] SCI = 64'h9e37_79b9_7f4a_7c15;
   localparam logic [63:0] OCI = 64'hc2b2_ae3d_27d4_eb4f;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic hostSelect = 1'b0;
   logic hostWriteEn = 1'b0;
   logic [17:0] hostAddr = 18'h0_0000;
   logic [3:0] hostNibbles = 4'h0;
   logic [31:0] hostDataIn = 32'h0000_0000;
   logic [31:0] hostDataOut, memWriteData, mem_data_bus;
   logic [15:0] mem_addr_bus;
   logic host_wait_release, xcvrEnable, cpuBufEnable, memEnable, memWriteEn;
   logic sysClockRun, ctrlClockPulse, dataClockPulse, ungatedOnly, forceGated;
   logic sysReset, irqRequest, shadowForceLoad, pipeLoadClk, opcLoadClk;
   logic storeWrite, storeInitLoad, shadowCapture, storeChainClk, opcChainClk;
   logic chainBitOut, storeChainBitIn, opcChainBitIn;
   logic [13:0] stb;
   int err_count = 0;
   int checks_done = 0;
   int cnt [14] = '{default: 0};
   int base [14];
   logic [31:0] mm [int];
   logic [31:0] portM;
   bit sq [$];
   bit oq [$];
   bit halted = 1'b0;
   hci_host_cmd i_hci_host_cmd (
      .clock(clock), .rst_b(rst_b), .hostSelect(hostSelect),
      .hostWriteEn(hostWriteEn), .hostAddr(hostAddr),
      .hostNibbles(hostNibbles), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .host_wait_release(host_wait_release),
      .xcvrEnable(xcvrEnable), .cpuBufEnable(cpuBufEnable),
      .memEnable(memEnable), .memWriteEn(memWriteEn),
      .mem_addr_bus(mem_addr_bus), .memWriteData(memWriteData),
      .mem_data_bus(mem_data_bus), .sysClockRun(sysClockRun),
      .ctrlClockPulse(ctrlClockPulse), .dataClockPulse(dataClockPulse),
      .ungatedOnly(ungatedOnly), .forceGated(forceGated),
      .sysReset(sysReset), .irqRequest(irqRequest),
      .shadowForceLoad(shadowForceLoad), .pipeLoadClk(pipeLoadClk),
      .opcLoadClk(opcLoadClk), .storeWrite(storeWrite),
      .storeInitLoad(storeInitLoad), .shadowCapture(shadowCapture),
      .storeChainClk(storeChainClk), .opcChainClk(opcChainClk),
      .chainBitOut(chainBitOut), .storeChainBitIn(storeChainBitIn),
      .opcChainBitIn(opcChainBitIn));
   hci_far_model #(.SC_INIT(SCI), .OC_INIT(OCI)) i_hci_far_model (
      .clock(clock), .memEnable(memEnable), .memWriteEn(memWriteEn),
      .memAddr(mem_addr_bus), .memWriteData(memWriteData),
      .memData(mem_data_bus), .storeChainClk(storeChainClk),
      .opcChainClk(opcChainClk), .chainBitOut(chainBitOut),
      .storeChainBit(storeChainBitIn), .opcChainBit(opcChainBitIn));
   initial begin
      forever #2.5 clock = ~clock;
   end
   // strobe counters, read as differences across one transaction
   assign stb = {shadowForceLoad, forceGated, opcChainClk, storeChainClk,
      shadowCapture, storeInitLoad, storeWrite, opcLoadClk, pipeLoadClk,
      irqRequest, sysReset, ungatedOnly, dataClockPulse, ctrlClockPulse};
   always @(posedge clock) begin
      for (int i = 0; i < 14; i++) if (rst_b) cnt[i] <= cnt[i] + int'(stb[i]);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one host bus transaction; select is held until ready is seen high
   task automatic xact(input logic [17:0] a, input logic we,
      input logic [31:0] d, input logic [3:0] n, output logic [31:0] q);
      int w;
      logic [2:0] bus;
      @(posedge clock);
      hostAddr <= a;
      hostWriteEn <= we;
      hostDataIn <= d;
      hostNibbles <= n;
      hostSelect <= 1'b1;
      base = cnt;
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (host_wait_release !== 1'b1 && w < 400);
      chk(w < 400, 1, "ready wait");
      q = hostDataOut;
      bus = {sysClockRun, xcvrEnable, cpuBufEnable};
      if (a[17] == 1'b0) chk(bus, 3'b010, "owned");
      if (a[17:16] == GRP_MEM) begin
         chk(mem_addr_bus, a[15:0], "word address");
      end
      hostSelect <= 1'b0;
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (host_wait_release !== 1'b0 && w < 20);
      chk(w < 20, 1, "ready drop");
      @(posedge clock);
      bus = {sysClockRun, xcvrEnable, cpuBufEnable};
      chk(bus, {~halted, 2'b01}, "released");
   endtask
   // strobes expected to pulse exactly once for a command
   function automatic logic [13:0] once(logic [1:0] g, logic [2:0] c);
      case ({g, c})
         {GRP_CPU, CPU_STEP}: return 14'h0003;
         {GRP_CPU, CPU_STEPC}: return 14'h0001;
         {GRP_CPU, CPU_STEPD}: return 14'h0002;
         {GRP_CPU, CPU_IRQ}: return 14'h0010;
         {GRP_DIAG, DG_LDPIPE}: return 14'h2020;
         {GRP_DIAG, DG_LDOPC}: return 14'h2040;
         {GRP_DIAG, DG_LDINIT}: return 14'h0100;
         {GRP_DIAG, DG_CAPTURE}: return 14'h0200;
         default: return 14'h0000;
      endcase
   endfunction
   task automatic cmd(input logic [1:0] g, input logic [2:0] c,
      input logic [3:0] n);
      logic [31:0] q;
      logic [13:0] o;
      int e;
      int nb;
      nb = (n == 4'h0) ? 32 : 4 * n;
      o = once(g, c);
      if (g == GRP_CPU && c == CPU_HALT) halted = 1'b1;
      if (g == GRP_CPU && c == CPU_RUN) halted = 1'b0;
      xact({g, 13'h0000, c}, 1'b0, 32'h0000_0000, n, q);
      for (int s = 0; s < 14; s++) begin
         e = int'(o[s]);
         if ({g, c} == {GRP_DIAG, DG_LDSTORE} && s == 7) e = STORE_CYCLES;
         if ({g, c} == {GRP_DIAG, DG_SHSTORE} && s == 10) e = nb;
         if ({g, c} == {GRP_DIAG, DG_SHOPC} && s == 11) e = nb;
         if ({g, c} == {GRP_CPU, CPU_RESET} && s < 4) e = (s == 3) ? -1 : 1;
         if (e >= 0) begin
            chk(32'(cnt[s] - base[s]), 32'(e), "strobe count");
         end
      end
      if ({g, c} == {GRP_CPU, CPU_RESET}) begin
         chk(32'(cnt[3] != base[3]), 1, "reset line");
      end
   endtask
   initial begin
      #200_000;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      logic [31:0] q;
      logic [31:0] d;
      logic [15:0] wd;
      logic [3:0] n;
      bit b;
      void'($urandom(32'he3ba_63f9));
      for (int i = 0; i < 64; i++) begin
         sq.push_back(SCI[i]);
         oq.push_back(OCI[i]);
      end
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      // idle state: no ready, processor owns its bus and its clock runs
      chk({host_wait_release, cpuBufEnable, sysClockRun}, 3'b011,
         "after reset");
      // back-to-back write and read of random words
      for (int k = 0; k < 4; k++) begin
         wd = 16'($urandom_range(255, 0));
         d = $urandom;
         xact({GRP_MEM, wd}, 1'b1, d, 4'h0, q);
         mm[wd] = d;
         xact({GRP_MEM, wd}, 1'b0, 32'h0000_0000, 4'h0, q);
         chk(q, mm[wd], "memory word");
      end
      $display("test memory done");
      cmd(GRP_CPU, CPU_HALT, 4'h0);
      // chains shift with clocks halted; full and partial nibble counts
      for (int k = 0; k < 6; k++) begin
         // a single-nibble shift is forced once so chk_shift_len fires
         n = (k < 2) ? 4'h0 : (k == 2) ? 4'h1 : 4'($urandom_range(8, 1));
         d = $urandom;
         xact({GRP_PORT, 16'h0000}, 1'b1, d, 4'h0, q);
         portM = d;
         cmd(GRP_DIAG, k[0] ? DG_SHOPC : DG_SHSTORE, n);
         repeat ((n == 4'h0) ? 32 : 4 * n) begin
            b = k[0] ? oq.pop_front() : sq.pop_front();
            if (k[0]) oq.push_back(portM[0]);
            else sq.push_back(portM[0]);
            portM = {b, portM[31:1]};
         end
         xact({GRP_PORT, 16'h0000}, 1'b0, 32'h0000_0000, 4'h0, q);
         chk(q, portM, "port after shift");
      end
      $display("test shift done");
      // codes start at 1: the zero code would hang the interpreter
      for (int c = 1; c < 6; c++) cmd(GRP_DIAG, 3'(c), 4'h0);
      $display("test diag done");
      for (int c = 3; c < 7; c++) cmd(GRP_CPU, 3'(c), 4'h0);
      cmd(GRP_CPU, CPU_RUN, 4'h0);
      cmd(GRP_CPU, CPU_RESET, 4'h0);
      $display("test cpu done");
      final_report();
   end
endmodule
`default_nettype wire
